// ==== include/eeps_link_if.sv ====
`timescale 1ns/100ps
interface eeps_link_if;
  logic sec_write;
  logic staging_select;
  logic reload_control;
  logic pulse_erase;
  logic pulse_write;
  logic ser_clk;
  logic ser_data;

  modport device (
    input sec_write,
    input staging_select,
    input reload_control,
    input pulse_erase,
    input pulse_write,
    input ser_clk,
    input ser_data
  );

  modport programmer (
    output sec_write,
    output staging_select,
    output reload_control,
    output pulse_erase,
    output pulse_write,
    output ser_clk,
    output ser_data
  );
endinterface : eeps_link_if

// ==== include/eeps_pkg.sv ====
package eeps_pkg;

  // ==========================================================
  // word and counter widths
  localparam int unsigned WORD_W = 20;
  localparam int unsigned BIT_W  = 5;
  localparam int unsigned CNT_W  = 22;
  localparam int unsigned WEAR_W = 16;

  // ==========================================================
  // timing, at a 100 MHz system clock
  localparam int unsigned CLK_KHZ    = 100000;
  localparam int unsigned PULSE_MS   = 25;
  localparam int unsigned SETTLE_US  = 20;
  localparam int unsigned GAP_US     = 1;
  localparam int unsigned PULSE_CYC  = PULSE_MS * CLK_KHZ;
  localparam logic [CNT_W-1:0] SETTLE_CYC = CNT_W'((SETTLE_US * CLK_KHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] GAP_CYC    = CNT_W'((GAP_US * CLK_KHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] SCLK_HALF_CYC = 22'h00000a;

  // ==========================================================
  // store contents and limits
  localparam logic [WORD_W-1:0] ERASED_WORD  = 20'hfffff;
  localparam logic [WORD_W-1:0] NV_INIT      = 20'h00000;
  localparam logic [WEAR_W-1:0] ENDURANCE_MIN = 16'h0064;
  localparam logic [BIT_W-1:0]  LAST_BIT     = 5'h13;

  // ==========================================================
  // programmer sequence
  typedef enum logic [3:0] {
    P_IDLE, P_ERASE_SETUP, P_ERASE_PULSE, P_ERASE_HOLD, P_LOAD,
    P_WRITE_SETUP, P_WRITE_PULSE, P_WRITE_HOLD, P_FINISH
  } eeps_state_type;

  // ==========================================================
  // helpers
  function automatic logic eeps_rise(input logic now, input logic prev);
    return now & ~prev;
  endfunction : eeps_rise

  function automatic logic eeps_fall(input logic now, input logic prev);
    return ~now & prev;
  endfunction : eeps_fall

  function automatic logic eeps_last(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] lim);
    return cnt == (lim - 22'h000001);
  endfunction : eeps_last

endpackage : eeps_pkg

// ==== rtl/eeps_device.sv ====
`timescale 1ns/100ps
module eeps_device #(
  parameter logic [eeps_pkg::CNT_W-1:0] PULSE_CYC = eeps_pkg::CNT_W'(eeps_pkg::PULSE_CYC)
) (
  input  wire logic                         sys_clk,
  input  wire logic                         rst_n,
  eeps_link_if.device                       link,
  input  wire logic                         power_good,
  input  wire logic [eeps_pkg::WORD_W-1:0]  alt_word,
  output logic      [eeps_pkg::WORD_W-1:0]  freq_word,
  output logic                              staging_in_use,
  output logic      [eeps_pkg::WORD_W-1:0]  nv_word,
  output logic      [eeps_pkg::WEAR_W-1:0]  wear_count,
  output logic                              endurance_spent,
  output logic                              pulse_rejected
);

  // ==========================================================
  // state
  logic [eeps_pkg::WORD_W-1:0] stg_q, stg_d, nv_q, nv_d, freq_q, freq_d;
  logic [eeps_pkg::CNT_W-1:0]  pcnt_q, pcnt_d, dly_q, dly_d;
  logic [eeps_pkg::WEAR_W-1:0] wear_q, wear_d;
  logic                        valid_q, valid_d, ok_q, ok_d, src_q, src_d, rej_q, rej_d;
  logic                        pclk_q, pload_q, pers_q, pwr_q;
  logic                        erase_mode, write_mode, pulse_end, settle_edge, load_edge;

  // ==========================================================
  // next state
  always_comb begin
    stg_d   = stg_q;
    nv_d    = nv_q;
    freq_d  = freq_q;
    pcnt_d  = pcnt_q;
    dly_d   = dly_q;
    wear_d  = wear_q;
    valid_d = valid_q;
    ok_d    = ok_q;
    src_d   = src_q;
    rej_d   = 1'b0;
    erase_mode = link.sec_write & link.staging_select & link.reload_control;
    write_mode = link.sec_write & ~link.staging_select & link.reload_control;
    pulse_end  = eeps_pkg::eeps_fall(link.pulse_erase, pers_q) | eeps_pkg::eeps_fall(link.pulse_write, pwr_q);
    // a pulse only counts if the mode lines stood for all of it
    if (link.pulse_erase | link.pulse_write) begin
      if (pcnt_q != {eeps_pkg::CNT_W{1'b1}}) begin
        pcnt_d = pcnt_q + 22'h000001;
      end
      if ((link.pulse_erase & link.pulse_write) | (link.pulse_erase & ~erase_mode) |
          (link.pulse_write & ~write_mode)) begin
        ok_d = 1'b0;
      end
    end
    if (pulse_end) begin
      if (ok_q && pcnt_q >= PULSE_CYC) begin
        if (pers_q) begin
          nv_d = eeps_pkg::ERASED_WORD;
        end else begin
          nv_d = nv_q & stg_q;
          if (wear_q != {eeps_pkg::WEAR_W{1'b1}}) begin
            wear_d = wear_q + 16'h0001;
          end
        end
      end else begin
        rej_d = 1'b1;
      end
      pcnt_d = '0;
      ok_d   = 1'b1;
    end
    // delayed select edge waits for stable power before the copy
    if (link.staging_select & power_good) begin
      if (dly_q != eeps_pkg::SETTLE_CYC) begin
        dly_d = dly_q + 22'h000001;
      end
    end else begin
      dly_d = '0;
    end
    settle_edge = link.staging_select & power_good & ~link.reload_control &
                  eeps_pkg::eeps_last(dly_q, eeps_pkg::SETTLE_CYC);
    load_edge   = link.staging_select & eeps_pkg::eeps_fall(link.reload_control, pload_q);
    if (settle_edge | load_edge) begin
      stg_d   = nv_q;
      valid_d = 1'b1;
    end else if (eeps_pkg::eeps_rise(link.ser_clk, pclk_q) & ~link.sec_write & link.reload_control) begin
      stg_d   = {link.ser_data, stg_q[eeps_pkg::WORD_W-1:1]};
      valid_d = 1'b0;
    end
    // shifted data never reaches the synthesizer; it takes alt_word unless select is high and reload low, then holds its word until the next copy from the store
    if (link.staging_select & ~link.reload_control) begin
      src_d = 1'b1;
      if (valid_q) begin
        freq_d = stg_q;
      end
    end else begin
      src_d  = 1'b0;
      freq_d = alt_word;
    end
  end

  // ==========================================================
  // registers; the store keeps a fixed initial image over reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stg_q   <= '0;
      nv_q    <= eeps_pkg::NV_INIT;
      freq_q  <= '0;
      pcnt_q  <= '0;
      dly_q   <= '0;
      wear_q  <= '0;
      valid_q <= 1'b0;
      ok_q    <= 1'b1;
      src_q   <= 1'b0;
      rej_q   <= 1'b0;
      pclk_q  <= 1'b0;
      pload_q <= 1'b0;
      pers_q  <= 1'b0;
      pwr_q   <= 1'b0;
    end else begin
      stg_q   <= stg_d;
      nv_q    <= nv_d;
      freq_q  <= freq_d;
      pcnt_q  <= pcnt_d;
      dly_q   <= dly_d;
      wear_q  <= wear_d;
      valid_q <= valid_d;
      ok_q    <= ok_d;
      src_q   <= src_d;
      rej_q   <= rej_d;
      pclk_q  <= link.ser_clk;
      pload_q <= link.reload_control;
      pers_q  <= link.pulse_erase;
      pwr_q   <= link.pulse_write;
    end
  end

  logic spent_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      spent_q <= 1'b0;
    end else begin
      spent_q <= wear_d >= eeps_pkg::ENDURANCE_MIN;
    end
  end

  assign freq_word       = freq_q;
  assign staging_in_use  = src_q;
  assign nv_word         = nv_q;
  assign wear_count      = wear_q;
  assign endurance_spent = spent_q;
  assign pulse_rejected  = rej_q;

endmodule : eeps_device

// ==== rtl/eeps_programmer.sv ====
// Contract
// - all twenty bits commit in parallel
// - write ANDs into store; erase first
// - erase: three lines high, one negative pulse; code drives a positive pulse
// - write: select low, others high, positive pulse
// - shift word into staging before write pulse
// - end programming by dropping reload control
// - keep reload control steady between load, write
// - store endures at least one hundred cycles
// - staging selected, copy after power stable
// - copy on delayed staging select rising edge
// - staging reloads from store, never serial data
// - staging drives synth when selected, reload low
// - shift on rising clock, lsb first
`timescale 1ns/100ps
module eeps_programmer #(
  parameter logic [eeps_pkg::CNT_W-1:0] PULSE_CYC = eeps_pkg::CNT_W'(eeps_pkg::PULSE_CYC)
) (
  input  wire logic                         sys_clk,
  input  wire logic                         rst_n,
  eeps_link_if.programmer                   link,
  input  wire logic                         start,
  input  wire logic                         abort,
  input  wire logic [eeps_pkg::WORD_W-1:0]  word_in,
  output logic                              busy,
  output logic                              done,
  output logic                              aborted
);

  // ==========================================================
  // state
  eeps_pkg::eeps_state_type    state_q, state_d;
  logic [eeps_pkg::CNT_W-1:0]  cnt_q, cnt_d;
  logic [eeps_pkg::BIT_W-1:0]  bit_q, bit_d;
  logic [eeps_pkg::WORD_W-1:0] word_q, word_d;
  logic sw_q, sw_d, sel_q, sel_d, load_q, load_d;
  logic ers_q, ers_d, wr_q, wr_d, sclk_q, sclk_d, sdat_q, sdat_d;
  logic busy_q, busy_d, done_q, done_d, abt_q, abt_d;
  logic [eeps_pkg::CNT_W-1:0]  cnt_inc;

  // ==========================================================
  // sequence
  always_comb begin
    state_d = state_q;
    cnt_inc = cnt_q + 22'h000001;
    cnt_d   = cnt_inc;
    bit_d   = bit_q;
    word_d  = word_q;
    sw_d    = sw_q;
    sel_d   = sel_q;
    load_d  = load_q;
    ers_d   = ers_q;
    wr_d    = wr_q;
    sclk_d  = sclk_q;
    sdat_d  = sdat_q;
    busy_d  = busy_q;
    done_d  = 1'b0;
    abt_d   = 1'b0;
    unique case (state_q)
      eeps_pkg::P_IDLE: begin
        cnt_d = '0;
        // idle lines leave the stored word in charge of the synthesizer
        sw_d   = 1'b0;
        sel_d  = 1'b1;
        load_d = 1'b0;
        if (start) begin
          word_d  = word_in;
          busy_d  = 1'b1;
          sw_d    = 1'b1;
          load_d  = 1'b1;
          state_d = eeps_pkg::P_ERASE_SETUP;
        end
      end
      eeps_pkg::P_ERASE_SETUP: begin
        if (eeps_pkg::eeps_last(cnt_q, eeps_pkg::GAP_CYC)) begin
          cnt_d   = '0;
          ers_d   = 1'b1;
          state_d = eeps_pkg::P_ERASE_PULSE;
        end
      end
      eeps_pkg::P_ERASE_PULSE: begin
        if (eeps_pkg::eeps_last(cnt_q, PULSE_CYC)) begin
          cnt_d   = '0;
          ers_d   = 1'b0;
          state_d = eeps_pkg::P_ERASE_HOLD;
        end
      end
      eeps_pkg::P_ERASE_HOLD: begin
        // the select line drops only a full gap after the pulse is gone
        if (eeps_pkg::eeps_last(cnt_q, eeps_pkg::GAP_CYC)) begin
          cnt_d   = '0;
          sw_d    = 1'b0;
          sel_d   = 1'b0;
          bit_d   = '0;
          sdat_d  = word_q[0];
          state_d = eeps_pkg::P_LOAD;
        end
      end
      eeps_pkg::P_LOAD: begin
        // reload control stays high from here until the write is over
        if (eeps_pkg::eeps_last(cnt_q, eeps_pkg::SCLK_HALF_CYC)) begin
          cnt_d = '0;
          if (!sclk_q) begin
            sclk_d = 1'b1;
          end else begin
            sclk_d = 1'b0;
            if (bit_q == eeps_pkg::LAST_BIT) begin
              sw_d    = 1'b1;
              state_d = eeps_pkg::P_WRITE_SETUP;
            end else begin
              bit_d  = bit_q + 5'h01;
              sdat_d = word_q[bit_q + 5'h01];
            end
          end
        end
      end
      eeps_pkg::P_WRITE_SETUP: begin
        if (eeps_pkg::eeps_last(cnt_q, eeps_pkg::GAP_CYC)) begin
          cnt_d   = '0;
          wr_d    = 1'b1;
          state_d = eeps_pkg::P_WRITE_PULSE;
        end
      end
      eeps_pkg::P_WRITE_PULSE: begin
        if (eeps_pkg::eeps_last(cnt_q, PULSE_CYC)) begin
          cnt_d   = '0;
          wr_d    = 1'b0;
          state_d = eeps_pkg::P_WRITE_HOLD;
        end
      end
      eeps_pkg::P_WRITE_HOLD: begin
        if (eeps_pkg::eeps_last(cnt_q, eeps_pkg::GAP_CYC)) begin
          cnt_d   = '0;
          load_d  = 1'b0;
          sw_d    = 1'b0;
          state_d = eeps_pkg::P_FINISH;
        end
      end
      eeps_pkg::P_FINISH: begin
        // raising select now lets the device reload the new word
        if (eeps_pkg::eeps_last(cnt_q, eeps_pkg::GAP_CYC)) begin
          cnt_d   = '0;
          sel_d   = 1'b1;
          busy_d  = 1'b0;
          done_d  = 1'b1;
          state_d = eeps_pkg::P_IDLE;
        end
      end
      default: begin
        cnt_d   = '0;
        state_d = eeps_pkg::P_IDLE;
      end
    endcase
    // abort kills any pulse and drops the mode lines in the same cycle, then returns to idle lines through P_FINISH
    if (abort && state_q != eeps_pkg::P_IDLE) begin
      ers_d   = 1'b0;
      wr_d    = 1'b0;
      sclk_d  = 1'b0;
      sw_d    = 1'b0;
      load_d  = 1'b0;
      sel_d   = 1'b0;
      cnt_d   = '0;
      busy_d  = 1'b0;
      abt_d   = 1'b1;
      state_d = eeps_pkg::P_FINISH;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= eeps_pkg::P_IDLE;
      cnt_q   <= '0;
      bit_q   <= '0;
      word_q  <= '0;
      sw_q    <= 1'b0;
      sel_q   <= 1'b1;
      load_q  <= 1'b0;
      ers_q   <= 1'b0;
      wr_q    <= 1'b0;
      sclk_q  <= 1'b0;
      sdat_q  <= 1'b0;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      abt_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      bit_q   <= bit_d;
      word_q  <= word_d;
      sw_q    <= sw_d;
      sel_q   <= sel_d;
      load_q  <= load_d;
      ers_q   <= ers_d;
      wr_q    <= wr_d;
      sclk_q  <= sclk_d;
      sdat_q  <= sdat_d;
      busy_q  <= busy_d;
      done_q  <= done_d;
      abt_q   <= abt_d;
    end
  end

  assign link.sec_write      = sw_q;
  assign link.staging_select = sel_q;
  assign link.reload_control = load_q;
  assign link.pulse_erase    = ers_q;
  assign link.pulse_write    = wr_q;
  assign link.ser_clk        = sclk_q;
  assign link.ser_data       = sdat_q;
  assign busy                = busy_q;
  assign done                = done_q;
  assign aborted             = abt_q;

endmodule : eeps_programmer

// ==== testbench/eeps_link_assertions.sv ====
`timescale 1ns/100ps
module eeps_link_assertions #(
  parameter logic [eeps_pkg::CNT_W-1:0] PULSE_CYC = eeps_pkg::CNT_W'(eeps_pkg::PULSE_CYC)
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sec_write,
  input wire logic staging_select,
  input wire logic reload_control,
  input wire logic pulse_erase,
  input wire logic pulse_write,
  input wire logic ser_clk,
  input wire logic ser_data
);
  // ==========================================================
  // helper state
  logic [eeps_pkg::CNT_W-1:0] run_q;
  logic [eeps_pkg::CNT_W-1:0] run_d;
  logic                       loaded_q;
  logic                       loaded_d;
  logic                       erased_q;
  logic                       erased_d;

  always_comb begin
    run_d    = (pulse_erase | pulse_write) ? run_q + 22'h000001 : '0;
    // staged word is at risk from the first shift clock until the write pulse
    loaded_d = (loaded_q | ser_clk) & ~pulse_write & ~staging_select;
    erased_d = pulse_erase | (erased_q & ~pulse_write);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q    <= '0;
      loaded_q <= 1'b0;
      erased_q <= 1'b0;
    end else begin
      run_q    <= run_d;
      loaded_q <= loaded_d;
      erased_q <= erased_d;
    end
  end

  // ==========================================================
  // link checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  erase_lines_a: assert property (pulse_erase |-> sec_write && staging_select && reload_control)
    else $error("erase pulse without erase mode lines");
  write_lines_a: assert property (pulse_write |-> sec_write && !staging_select && reload_control)
    else $error("write pulse without write mode lines");
  pulse_excl_a: assert property (!(pulse_erase && pulse_write))
    else $error("both programming pulses at once");
  erase_len_a: assert property ($fell(pulse_erase) |-> run_q == PULSE_CYC)
    else $error("erase pulse length wrong");
  write_len_a: assert property ($fell(pulse_write) |-> run_q == PULSE_CYC)
    else $error("write pulse length wrong");
  lines_steady_a: assert property ((pulse_erase || pulse_write) && $past(pulse_erase || pulse_write)
    |-> $stable({sec_write, staging_select, reload_control})) else $error("mode lines moved in pulse");
  reload_hold_a: assert property (loaded_q && $past(loaded_q) |-> $stable(reload_control))
    else $error("reload line moved before write pulse");
  reload_drop_a: assert property ($fell(pulse_write) |-> ##[1:150] !reload_control)
    else $error("reload line not dropped after write");
  erase_first_a: assert property ($rose(pulse_write) |-> erased_q)
    else $error("write pulse without prior erase");
  select_after_a: assert property ($fell(staging_select) |-> !pulse_erase && !$past(pulse_erase))
    else $error("select dropped during erase pulse");
  shift_data_a: assert property ($rose(ser_clk) |-> $stable(ser_data))
    else $error("serial data moved at shift edge");
endmodule : eeps_link_assertions

// ==== testbench/eeps_program_sequencer_tb.sv ====
`timescale 1ns/100ps
module eeps_program_sequencer_tb;
  // short pulse keeps the run small; both ends and checker share it
  localparam logic [eeps_pkg::CNT_W-1:0] PCYC = 22'h000032;
  logic                        sys_clk, rst_n, power_good, start, abort;
  logic [eeps_pkg::WORD_W-1:0] word_in, alt_word, freq_word, nv_word;
  logic [eeps_pkg::WEAR_W-1:0] wear_count;
  logic                        staging_in_use, endurance_spent, pulse_rejected, busy, done, aborted;
  logic                        got_done, got_abort, rej_seen;
  int                          err_total, compares, cyc;

  eeps_link_if link ();
  eeps_device #(.PULSE_CYC(PCYC)) eeps_device_inst (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
    .power_good(power_good), .alt_word(alt_word), .freq_word(freq_word), .staging_in_use(staging_in_use),
    .nv_word(nv_word), .wear_count(wear_count), .endurance_spent(endurance_spent),
    .pulse_rejected(pulse_rejected));
  eeps_programmer #(.PULSE_CYC(PCYC)) eeps_programmer_inst (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
    .start(start), .abort(abort), .word_in(word_in), .busy(busy), .done(done), .aborted(aborted));
  eeps_link_assertions #(.PULSE_CYC(PCYC)) eeps_link_assertions_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .sec_write(link.sec_write), .staging_select(link.staging_select), .reload_control(link.reload_control),
    .pulse_erase(link.pulse_erase), .pulse_write(link.pulse_write), .ser_clk(link.ser_clk),
    .ser_data(link.ser_data));

  // ==========================================================
  // compare and report
  task automatic chk_word(input string what, input logic [19:0] exp, input logic [19:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_flag(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_flag

  task automatic end_sim();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  // ==========================================================
  // helpers
  task automatic kick(input logic [19:0] w);
    @(posedge sys_clk);
    start   <= 1'b1;
    word_in <= w;
    @(posedge sys_clk);
    start   <= 1'b0;
  endtask : kick

  task automatic await_end();
    got_done  = 1'b0;
    got_abort = 1'b0;
    repeat (3000) begin
      @(posedge sys_clk);
      #1;
      if (done === 1'b1) got_done = 1'b1;
      if (aborted === 1'b1) got_abort = 1'b1;
      if (got_done || got_abort) break;
    end
  endtask : await_end

  // settle delay plus margin, so the power-up style copy has landed
  task automatic settle();
    repeat (2100) @(posedge sys_clk);
    #1;
  endtask : settle

  task automatic prog(input logic [19:0] w, input logic [15:0] wear);
    kick(w);
    repeat (500) begin
      @(posedge sys_clk);
      if (link.staging_select === 1'b0) break;
    end
    repeat (3) @(posedge sys_clk);
    #1;
    chk_word("alt source", alt_word, freq_word);
    chk_flag("staging used", 1'b0, staging_in_use);
    kick(20'h00001);
    await_end();
    chk_flag("done seen", 1'b1, got_done);
    chk_word("store word", w, nv_word);
    chk_word("wear", {4'h0, wear}, {4'h0, wear_count});
    chk_flag("no rejected pulse", 1'b0, rej_seen);
    @(posedge sys_clk);
    #1;
    chk_flag("busy after start refused", 1'b0, busy);
    settle();
    chk_word("staged freq", w, freq_word);
    chk_flag("staging used", 1'b1, staging_in_use);
  endtask : prog

  // ==========================================================
  // scenarios
  task automatic s_power_up();
    repeat (40) @(posedge sys_clk);
    power_good <= 1'b1;
    settle();
    chk_word("reset store", eeps_pkg::NV_INIT, nv_word);
    chk_word("powered freq", eeps_pkg::NV_INIT, freq_word);
    chk_flag("staging used", 1'b1, staging_in_use);
    chk_flag("worn out", 1'b0, endurance_spent);
  endtask : s_power_up

  task automatic s_first_write();
    prog(20'h12345, 16'h0001);
  endtask : s_first_write

  task automatic s_rewrite();
    // bits outside the first word prove the erase ran before the AND write
    prog(20'ha5a5a, 16'h0002);
  endtask : s_rewrite

  task automatic s_abort();
    kick(20'h00ff0);
    repeat (500) begin
      @(posedge sys_clk);
      if (link.pulse_erase === 1'b1) break;
    end
    repeat (70) @(posedge sys_clk);
    abort <= 1'b1;
    @(posedge sys_clk);
    abort <= 1'b0;
    // the aborted pulse stands for this one cycle only
    #1;
    chk_flag("aborted pulse", 1'b1, aborted);
    chk_flag("busy after abort", 1'b0, busy);
    await_end();
    chk_flag("done after abort", 1'b1, got_done);
    chk_word("erased store", eeps_pkg::ERASED_WORD, nv_word);
    chk_word("wear", 20'h00002, {4'h0, wear_count});
    chk_flag("no rejected pulse", 1'b0, rej_seen);
    settle();
    chk_word("reloaded freq", eeps_pkg::ERASED_WORD, freq_word);
  endtask : s_abort

  // ==========================================================
  // clock, reset, timeout, sequence
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // a refused pulse is latched so a later compare can see it
  always @(posedge sys_clk) begin
    if (pulse_rejected === 1'b1) begin
      rej_seen <= 1'b1;
    end
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end

  initial begin
    rst_n      = 1'b0;
    power_good = 1'b0;
    start      = 1'b0;
    abort      = 1'b0;
    word_in    = 20'h00000;
    alt_word   = 20'h5a5a5;
    err_total  = 0;
    compares   = 0;
    cyc        = 0;
    rej_seen   = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    s_power_up();
    s_first_write();
    s_rewrite();
    s_abort();
    end_sim();
  end
endmodule : eeps_program_sequencer_tb
